// >>> verilog/isa_defs.vh
// Purpose: constants for the two-wire slave address/ack/receive block
// Assumes: 100 MHz system clock
// Notes: mode codes are local choices
`ifndef ISA_DEFS_VH
`define ISA_DEFS_VH
`define ISA_MODE_7BIT 2'h0
`define ISA_MODE_10BIT 2'h1
`define ISA_MODE_7BIT_SP 2'h2
`define ISA_MODE_10BIT_SP 2'h3
`define ISA_MODE_TEN_BIT 0
`define ISA_MODE_SP_BIT 1
`define ISA_TEN_HIGH_PREFIX 5'h1E
`define ISA_ACK_BIT_COUNT 4'h8
`define ISA_BUF_DEPTH 2
`endif

// >>> verilog/isa_sync.v
// Purpose: three-flop synchroniser with agreement filter
// Assumes: input from outside the sys_clk domain
// Notes: output changes only once stages two and three agree
`timescale 1ns/100ps
module isa_sync (
  input wire sys_clk,
  input wire reset,
  input wire async_in,
  output reg sync_out
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        sync_out <= s3_q;
      end
    end
  end
endmodule

// >>> verilog/isa_buf.v
// Purpose: two-entry byte buffer with valid/ready on both sides
// Assumes: same clock on both sides
// Notes: read data are a combinational mux of the entry at the read pointer
`timescale 1ns/100ps
`include "isa_defs.vh"
module isa_buf (
  input wire sys_clk,
  input wire reset,
  input wire [7:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [7:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [7:0] mem_q [0:1];
  reg wp_q;
  reg rp_q;
  reg [1:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  always @(posedge sys_clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
  always @* begin
    out_data = mem_q[rp_q];
  end
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// >>> verilog/isa_slave.v
// Purpose: two-wire slave front end: address match, acknowledge, byte receive
// Assumes: an external master drives SCL; SDA/SCL are open-drain three-signal pins
// Notes: no slave transmit, master mode or collision logic
// Behaviour
// - start/stop irq enables add interrupts where missing
// - ninth pulse carries acknowledge, low means ack
// - sampled acknowledge stored in ack status
// - hold modes send software ack data bit
// - no hold modes: hardware acks automatically
// - full without overwrite enable, no buffer space, or overflow gives not-acknowledge
// - ack time flag after eighth fall, holds only
// - four modes, seven and ten bit
// - start/stop modes interrupt on every condition
// - first byte compared; match buffers and interrupts
// - mask register gates compared address bits
// - seven bit mode ignores address lsb
// - ten bit high byte is 11110 A9 A8 0
// - after high ack set update flag, hold SCL
// - low byte compared fully; always update and hold
// - ten bit read needs prior full write match
// - write match clears rw, buffers, acknowledges
// - interrupt per byte until software clears
// - stretch enable holds SCL until release
// - reading buffer clears full flag
// - start and stop status bits; stop idles
// - start/stop are SDA edges while SCL high
// - restart resets slave like a start
// - SDA sampled on SCL rising edge
`timescale 1ns/100ps
`include "isa_defs.vh"
module isa_slave (
  input wire sys_clk,
  input wire reset,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire enable,
  input wire [1:0] mode_select_field,
  input wire [7:0] own_address_reg,
  input wire own_address_write,
  input wire [7:0] address_mask,
  input wire address_hold_enable,
  input wire data_hold_enable,
  input wire stretch_enable,
  input wire buffer_overwrite_enable,
  input wire start_irq_enable,
  input wire stop_irq_enable,
  input wire ack_data_bit,
  input wire clock_release_set,
  input wire irq_flag_clear,
  input wire overflow_clear,
  output wire [7:0] rx_data,
  output wire rx_valid,
  input wire rx_ready,
  output reg serial_irq_flag,
  output reg buffer_full_flag,
  output reg receive_overflow_flag,
  output reg ack_status_bit,
  output reg ack_time_flag,
  output reg update_address_flag,
  output reg start_flag,
  output reg stop_flag,
  output reg read_write_flag,
  output reg data_address_flag,
  output reg clock_release_bit
);
  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam ST_IDLE = 5'h01;
  localparam ST_ADDR = 5'h02;
  localparam ST_LOW = 5'h04;
  localparam ST_DATA = 5'h08;
  localparam ST_ACK = 5'h10;

  // ------------------------------------------------------------
  // pin synchronisation and condition detection
  // ------------------------------------------------------------
  wire scl_s;
  wire sda_s;
  reg scl_q;
  reg sda_q;
  isa_sync u_scl (.sys_clk(sys_clk), .reset(reset), .async_in(scl_in), .sync_out(scl_s));
  isa_sync u_sda (.sys_clk(sys_clk), .reset(reset), .async_in(sda_in), .sync_out(sda_s));
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end
  wire scl_rise = scl_s && !scl_q;
  wire scl_fall = !scl_s && scl_q;
  wire start_det = enable && scl_s && scl_q && sda_q && !sda_s;
  wire stop_det = enable && scl_s && scl_q && !sda_q && sda_s;

  // ------------------------------------------------------------
  // address match helpers
  // ------------------------------------------------------------
  function match_bits;
    input [7:0] rx;
    input [7:0] ref_val;
    input [7:0] mask;
    input [7:0] care;
    begin
      match_bits = (((rx ^ ref_val) & mask & care) == 8'h00);
    end
  endfunction

  wire ten_mode = mode_select_field[`ISA_MODE_TEN_BIT];
  wire sp_mode = mode_select_field[`ISA_MODE_SP_BIT];
  wire hold_on = address_hold_enable || data_hold_enable;

  // ------------------------------------------------------------
  // byte engine
  // ------------------------------------------------------------
  reg [4:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [7:0] cur_byte_q;
  reg ack_drive_q;
  reg scl_hold_q;
  reg ack_given_q;
  reg prior_match_q;
  reg high_pending_q;
  reg ua_kind_low_q;
  reg post_ack_hold_q;
  reg push_q;
  reg [7:0] push_data_q;
  wire buf_in_ready;
  wire [7:0] shift_next = {shift_q[6:0], sda_s};
  wire overflow_now = buffer_full_flag || receive_overflow_flag;

  isa_buf u_buf (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_data(push_data_q),
    .in_valid(push_q),
    .in_ready(buf_in_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  wire pop = rx_valid && rx_ready;
  reg ack_decision;
  always @* begin
    ack_decision = 1'b0;
    if (hold_on) begin
      ack_decision = !ack_data_bit;
    end else begin
      ack_decision = 1'b1;
    end
    if (overflow_now && !buffer_overwrite_enable) begin
      ack_decision = 1'b0;
    end
    if (receive_overflow_flag) begin
      ack_decision = 1'b0;
    end
    if (!buf_in_ready) begin
      ack_decision = 1'b0;
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      cur_byte_q <= 8'h00;
      ack_drive_q <= 1'b0;
      scl_hold_q <= 1'b0;
      ack_given_q <= 1'b0;
      prior_match_q <= 1'b0;
      high_pending_q <= 1'b0;
      ua_kind_low_q <= 1'b0;
      post_ack_hold_q <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= 8'h00;
      serial_irq_flag <= 1'b0;
      buffer_full_flag <= 1'b0;
      receive_overflow_flag <= 1'b0;
      ack_status_bit <= 1'b0;
      ack_time_flag <= 1'b0;
      update_address_flag <= 1'b0;
      start_flag <= 1'b0;
      stop_flag <= 1'b0;
      read_write_flag <= 1'b0;
      data_address_flag <= 1'b0;
      clock_release_bit <= 1'b1;
    end else begin
      push_q <= 1'b0;
      // software clears first so that hardware sets below win
      if (irq_flag_clear) begin
        serial_irq_flag <= 1'b0;
      end
      if (overflow_clear) begin
        receive_overflow_flag <= 1'b0;
      end
      if (pop) begin
        buffer_full_flag <= (rx_valid && 1'b0);
      end
      if (clock_release_set) begin
        clock_release_bit <= 1'b1;
        if (!update_address_flag && !post_ack_hold_q) begin
          scl_hold_q <= 1'b0;
        end
      end
      if (own_address_write && update_address_flag) begin
        update_address_flag <= 1'b0;
        scl_hold_q <= 1'b0;
      end
      if (start_det) begin
        // restart takes the same path as start
        state_q <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        ack_drive_q <= 1'b0;
        scl_hold_q <= 1'b0;
        start_flag <= 1'b1;
        stop_flag <= 1'b0;
        if (sp_mode || start_irq_enable) begin
          serial_irq_flag <= 1'b1;
        end
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        stop_flag <= 1'b1;
        start_flag <= 1'b0;
        ack_drive_q <= 1'b0;
        scl_hold_q <= 1'b0;
        prior_match_q <= 1'b0;
        if (sp_mode || stop_irq_enable) begin
          serial_irq_flag <= 1'b1;
        end
      end else begin
        case (state_q)
          ST_IDLE: begin
            ack_drive_q <= 1'b0;
          end
          ST_ADDR, ST_LOW, ST_DATA: begin
            if (scl_rise) begin
              shift_q <= shift_next;
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (scl_fall && bit_cnt_q == `ISA_ACK_BIT_COUNT) begin
              bit_cnt_q <= 4'h0;
              cur_byte_q <= shift_q;
              if (state_q == ST_ADDR && !ten_mode) begin
                if (match_bits(shift_q, own_address_reg, address_mask, 8'hFE)) begin
                  read_write_flag <= shift_q[0];
                  data_address_flag <= 1'b0;
                  ack_given_q <= ack_decision;
                  ack_drive_q <= ack_decision && !address_hold_enable;
                  state_q <= ST_ACK;
                end else begin
                  state_q <= ST_IDLE;
                end
              end else if (state_q == ST_ADDR) begin
                if (shift_q[7:3] == `ISA_TEN_HIGH_PREFIX &&
                    match_bits({shift_q[7:1], 1'b0},
                               {`ISA_TEN_HIGH_PREFIX, own_address_reg[2:1], 1'b0},
                               address_mask, 8'h06) &&
                    (!shift_q[0] || prior_match_q)) begin
                  read_write_flag <= shift_q[0];
                  high_pending_q <= !shift_q[0];
                  ack_given_q <= ack_decision;
                  ack_drive_q <= ack_decision && !address_hold_enable;
                  state_q <= ST_ACK;
                end else begin
                  prior_match_q <= 1'b0;
                  state_q <= ST_IDLE;
                end
              end else if (state_q == ST_LOW) begin
                // low byte always interrupts and holds
                serial_irq_flag <= 1'b1;
                update_address_flag <= 1'b1;
                scl_hold_q <= 1'b1;
                if (match_bits(shift_q, own_address_reg, address_mask, 8'hFF)) begin
                  prior_match_q <= 1'b1;
                  ack_given_q <= ack_decision;
                  ack_drive_q <= ack_decision && !address_hold_enable;
                  ua_kind_low_q <= 1'b1;
                  state_q <= ST_ACK;
                end else begin
                  ua_kind_low_q <= 1'b0;
                  state_q <= ST_IDLE;
                end
              end else begin
                data_address_flag <= 1'b1;
                ack_given_q <= ack_decision;
                ack_drive_q <= ack_decision && !data_hold_enable;
                state_q <= ST_ACK;
              end
              if (overflow_now && state_q != ST_IDLE) begin
                receive_overflow_flag <= buffer_full_flag;
              end
              if (hold_on && ((state_q == ST_DATA && data_hold_enable) ||
                  (state_q != ST_DATA && address_hold_enable))) begin
                ack_time_flag <= 1'b1;
                serial_irq_flag <= 1'b1;
                scl_hold_q <= 1'b1;
                clock_release_bit <= 1'b0;
                post_ack_hold_q <= 1'b1;
              end else begin
                post_ack_hold_q <= 1'b0;
              end
            end
          end
          ST_ACK: begin
            if (post_ack_hold_q && clock_release_set) begin
              // software decided the response; drive it now
              ack_given_q <= ack_decision;
              ack_drive_q <= ack_decision;
              post_ack_hold_q <= 1'b0;
            end else if (!post_ack_hold_q && !update_address_flag) begin
              // ack already stands, so SCL may rise now
              scl_hold_q <= 1'b0;
            end
            if (scl_rise) begin
              ack_status_bit <= sda_s;
            end
            if (scl_fall) begin
              ack_drive_q <= 1'b0;
              ack_time_flag <= 1'b0;
              if (ack_given_q) begin
                push_q <= 1'b1;
                push_data_q <= cur_byte_q;
                buffer_full_flag <= 1'b1;
                serial_irq_flag <= 1'b1;
                if (high_pending_q) begin
                  high_pending_q <= 1'b0;
                  update_address_flag <= 1'b1;
                  scl_hold_q <= 1'b1;
                  state_q <= ST_LOW;
                end else if (read_write_flag) begin
                  state_q <= ST_IDLE;
                  scl_hold_q <= 1'b1;
                  clock_release_bit <= 1'b0;
                end else begin
                  if (ua_kind_low_q) begin
                    ua_kind_low_q <= 1'b0;
                  end else if (stretch_enable) begin
                    scl_hold_q <= 1'b1;
                    clock_release_bit <= 1'b0;
                  end
                  state_q <= ST_DATA;
                end
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // open-drain pins: only ever pull low
  // ------------------------------------------------------------
  assign sda_out = 1'b0;
  assign sda_oe = ack_drive_q;
  assign scl_out = 1'b0;
  assign scl_oe = scl_hold_q && !scl_s;
endmodule

// >>> tb/isa_slave_props.sv
// Purpose: port-level checks for the two-wire slave front end
// Assumes: single sys_clk domain, asynchronous active-high reset
// Notes: bound into every isa_slave instance
`timescale 1ns/100ps
module isa_slave_props (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic own_address_write,
  input wire logic address_hold_enable,
  input wire logic data_hold_enable,
  input wire logic buffer_overwrite_enable,
  input wire logic clock_release_set,
  input wire logic irq_flag_clear,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic serial_irq_flag,
  input wire logic buffer_full_flag,
  input wire logic ack_time_flag,
  input wire logic update_address_flag,
  input wire logic start_flag,
  input wire logic stop_flag
);
  // ------------------------------
  // properties
  // ------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence ack_rise_s;
    $rose(sda_oe);
  endsequence
  sequence ack_stand_s;
    sda_oe [*8];
  endsequence
  pins_zero_a: assert property (!scl_out && !sda_out) else $error("pin data not zero");
  ack_stand_a: assert property (ack_rise_s |-> ack_stand_s) else $error("ack too short");
  ack_edge_a: assert property (ack_rise_s |-> !scl_in) else $error("ack with scl high");
  full_nack_a: assert property (ack_rise_s and (!address_hold_enable && !data_hold_enable)
    |-> !(buffer_full_flag && !buffer_overwrite_enable)) else $error("ack while full");
  ack_time_a: assert property ($rose(ack_time_flag)
    |-> address_hold_enable || data_hold_enable) else $error("ack time flag");
  ua_clear_a: assert property (update_address_flag && own_address_write
    |=> !update_address_flag) else $error("update flag kept");
  ua_hold_a: assert property ($rose(update_address_flag)
    |-> ##[0:2] scl_oe) else $error("no hold on update");
  stretch_keep_a: assert property (scl_oe && !clock_release_set
    && !$past(clock_release_set) && !own_address_write && !$past(own_address_write)
    |=> scl_oe) else $error("scl hold dropped");
  irq_keep_a: assert property (serial_irq_flag && !irq_flag_clear
    |=> serial_irq_flag) else $error("irq lost");
  pop_clear_a: assert property (rx_valid && rx_ready
    |=> !buffer_full_flag) else $error("full after pop");
  start_high_a: assert property ($rose(start_flag) |-> scl_in) else $error("bad start");
  stop_idle_a: assert property ($rose(stop_flag)
    |-> scl_in && sda_in) else $error("bad stop");
endmodule
bind isa_slave isa_slave_props chk_u (.sys_clk, .reset, .scl_in, .scl_out, .scl_oe, .sda_in,
  .sda_out, .sda_oe, .own_address_write, .address_hold_enable, .data_hold_enable,
  .buffer_overwrite_enable, .clock_release_set, .irq_flag_clear, .rx_valid, .rx_ready,
  .serial_irq_flag, .buffer_full_flag, .ack_time_flag, .update_address_flag, .start_flag,
  .stop_flag);

// >>> tb/isa_bus_master.sv
// Purpose: behavioural two-wire bus master, 160 ns bit period
// Assumes: pull-ups on both lines, wired-and done by the bench
// Notes: scl stands high between frames
`timescale 1ns/100ps
module isa_bus_master (
  output logic scl_low,
  output logic sda_low,
  input wire logic scl,
  input wire logic sda
);
  initial begin
    scl_low = 0;
    sda_low = 0;
  end
  // one bit: data set in low phase, sampled in high phase
  task automatic clk_bit(input logic b, output logic s);
    #20 sda_low = !b;
    #60 scl_low = 0;
    wait (scl === 1'b1);
    #40 s = sda;
    #40 scl_low = 1;
  endtask
  task automatic start();
    #20 sda_low = 0;
    #60 scl_low = 0;
    wait (scl === 1'b1);
    #80 sda_low = 1;
    #80 scl_low = 1;
  endtask
  task automatic stop();
    #20 sda_low = 1;
    #60 scl_low = 0;
    wait (scl === 1'b1);
    #80 sda_low = 0;
    #80;
  endtask
  task automatic xfer(input logic [7:0] b, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, nack);
  endtask
endmodule

// >>> tb/testbench.sv
// Purpose: self-checking bench for the two-wire slave front end
// Assumes: 100 MHz sys_clk, bus bit period 160 ns
// Notes: a background process plays software during clock holds
`timescale 1ns/100ps
`include "isa_defs.vh"
module testbench;
  logic sys_clk = 0, reset = 1, enable = 1, own_address_write = 0, address_hold_enable = 0;
  logic data_hold_enable = 0, stretch_enable = 0, buffer_overwrite_enable = 0, rx_ready = 0;
  logic start_irq_enable = 0, stop_irq_enable = 0, ack_data_bit = 0, clock_release_set = 0;
  logic irq_flag_clear = 0, overflow_clear = 0, m_scl_low, m_sda_low, nk;
  logic [1:0] mode_select_field = `ISA_MODE_7BIT;
  logic [7:0] own_address_reg = 8'h00, address_mask = 8'hFF, next_addr = 8'h00;
  logic [7:0] rx_data, own, msk, rx, d;
  logic scl_out, scl_oe, sda_out, sda_oe, rx_valid, serial_irq_flag, buffer_full_flag;
  logic receive_overflow_flag, ack_status_bit, ack_time_flag, update_address_flag;
  logic start_flag, stop_flag, read_write_flag, data_address_flag, clock_release_bit;
  logic seen_ack_time_flag, seen_ua, seen_ckp;
  logic [31:0] seed = 32'h74058991, r;
  int fail_count = 0, checked = 0, cycles = 0, hold_n = 0;
  wire scl_in = !(m_scl_low | scl_oe);
  wire sda_in = !(m_sda_low | sda_oe);
  always #5 sys_clk = !sys_clk;
  isa_slave dut_u (.sys_clk, .reset, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe,
    .enable, .mode_select_field, .own_address_reg, .own_address_write, .address_mask,
    .address_hold_enable, .data_hold_enable, .stretch_enable, .buffer_overwrite_enable,
    .start_irq_enable, .stop_irq_enable, .ack_data_bit, .clock_release_set, .irq_flag_clear,
    .overflow_clear, .rx_data, .rx_valid, .rx_ready, .serial_irq_flag, .buffer_full_flag,
    .receive_overflow_flag, .ack_status_bit, .ack_time_flag, .update_address_flag, .start_flag,
    .stop_flag, .read_write_flag, .data_address_flag, .clock_release_bit);
  isa_bus_master mst_u (.scl_low(m_scl_low), .sda_low(m_sda_low), .scl(scl_in), .sda(sda_in));
  // ------------------------------
  // helpers
  // ------------------------------
  task tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pop(input logic [7:0] exp);
    int n = 0;
    while (rx_valid !== 1'b1 && n < 100) begin
      tick;
      n++;
    end
    chk("rx_data", exp, rx_data);
    rx_ready = 1;
    tick;
    rx_ready = 0;
  endtask
  task irq_clr;
    irq_flag_clear = 1;
    tick;
    irq_flag_clear = 0;
    tick;
  endtask
  function automatic logic exp_nack(input logic [7:0] o, m, a);
    return ((o ^ a) & m & 8'hFE) != 8'h00;
  endfunction
  task summarize;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // software side: release a held clock after 30 cycles
  always @(posedge sys_clk) begin
    #1;
    own_address_write = 0;
    clock_release_set = 0;
    hold_n = scl_oe ? hold_n + 1 : 0;
    if (hold_n == 30) begin
      seen_ack_time_flag = ack_time_flag;
      seen_ua = update_address_flag;
      seen_ckp = clock_release_bit;
      if (update_address_flag) begin
        own_address_reg = next_addr;
        own_address_write = 1;
      end else begin
        clock_release_set = 1;
      end
    end
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      summarize;
    end
  end
  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    #1 reset = 0;
    repeat (4) tick;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 2; k++) begin
        mode_select_field = m;
        start_irq_enable = k;
        stop_irq_enable = k;
        irq_clr;
        mst_u.start();
        repeat (10) tick;
        chk("start", 1, start_flag);
        chk("irq start", m[1] | k, serial_irq_flag);
        irq_clr;
        mst_u.stop();
        repeat (10) tick;
        chk("stop", 1, stop_flag);
        chk("irq stop", m[1] | k, serial_irq_flag);
      end
    end
    $display("modes done");
    start_irq_enable = 0;
    stop_irq_enable = 0;
    mode_select_field = `ISA_MODE_7BIT;
    for (int i = 0; i < 10; i++) begin
      irq_clr;
      own = $random(seed);
      msk = $random(seed);
      r = $random(seed);
      rx = {own[7:1] ^ (r[7:1] & (r[8] ? 7'h7F : ~msk[7:1])), 1'b0};
      own_address_reg = own;
      address_mask = msk;
      mst_u.start();
      mst_u.xfer(rx, nk);
      chk("addr nack", exp_nack(own, msk, rx), nk);
      repeat (10) tick;
      chk("irq", !exp_nack(own, msk, rx), serial_irq_flag);
      if (!nk) begin
        pop(rx);
        chk("rw", 0, read_write_flag);
        d = $random(seed);
        mst_u.xfer(d, nk);
        chk("data nack", 0, nk);
        pop(d);
        chk("irq held", 1, serial_irq_flag);
        mst_u.start();
        mst_u.xfer(rx, nk);
        chk("restart nack", 0, nk);
        pop(rx);
      end
      mst_u.stop();
    end
    $display("address match done");
    own_address_reg = 8'hA4;
    address_mask = 8'hFF;
    mst_u.start();
    mst_u.xfer(8'hA4, nk);
    mst_u.xfer(8'h5A, nk);
    chk("full nack", 1, nk);
    chk("full", 1, buffer_full_flag);
    mst_u.stop();
    pop(8'hA4);
    chk("full clr", 0, buffer_full_flag);
    overflow_clear = 1;
    tick;
    overflow_clear = 0;
    $display("overflow done");
    address_hold_enable = 1;
    for (int k = 0; k < 2; k++) begin
      ack_data_bit = k;
      mst_u.start();
      mst_u.xfer(8'hA4, nk);
      chk("hold nack", k, nk);
      chk("ack time", 1, seen_ack_time_flag);
      mst_u.stop();
      if (k == 0) pop(8'hA4);
    end
    address_hold_enable = 0;
    ack_data_bit = 0;
    $display("hold done");
    stretch_enable = 1;
    rx_ready = 1;
    mst_u.start();
    mst_u.xfer(8'hA4, nk);
    mst_u.xfer(8'h3C, nk);
    chk("stretch nack", 0, nk);
    chk("release bit", 0, seen_ckp);
    chk("ack time off", 0, seen_ack_time_flag);
    mst_u.stop();
    stretch_enable = 0;
    $display("stretch done");
    mode_select_field = `ISA_MODE_10BIT;
    r = $random(seed);
    own_address_reg = {5'h00, r[9:8], 1'b0};
    for (int k = 0; k < 2; k++) begin
      next_addr = r[7:0];
      mst_u.start();
      mst_u.xfer({`ISA_TEN_HIGH_PREFIX, r[9:8], 1'b0}, nk);
      chk("high nack", 0, nk);
      repeat (50) tick;
      chk("ua high", 1, seen_ua);
      next_addr = {5'h00, r[9:8], 1'b0};
      mst_u.xfer(r[7:0] ^ k, nk);
      chk("low nack", k, nk);
      mst_u.stop();
      chk("ua low", 1, seen_ua);
      chk("ua clr", 0, update_address_flag);
    end
    rx_ready = 0;
    $display("ten bit done");
    summarize;
  end
endmodule
